// [rmss_top.sv]
// Reset handling, strap sampling, bus-cycle sequencer and prefetch queue.
// Assumes one 10 MHz clock, a board reset pin and pulled-up shared pins.
//
// Summary of operation
// RL1: Reset persists for as long as the reset pin is held low.
// RL2: Reset pin is synchronised before internal use; needs a running clock.
// RL3: Board holds reset low from power-on.
// RL4: Reset ends any bus cycle at once and returns to idle.
// RL5: On abort, control outputs driven inactive first, then floated.
// RL6: During reset the shared strap pins are inputs, weakly pulled up; here they stay driven inactive until the abort state ends.
// RL7: Both memory selects low in reset select isolation test mode.
// RL8: Board holds isolation straps one output clock around release.
// RL9: Read strobe strap low in reset selects queue status mode.
// RL10: Busy pin high at release, low four clocks later, enables numerics.
// RL11: Board never pulls bus lock low during reset.
// RL12: Latched low address changes only as the first bus state ends.
// RL13: Strobes last about two output clocks, plus wait states.
// RL14: Buffer enable goes inactive before direction turns to receive.
// RL15: Wide bus variant has a six-byte prefetch queue.
// RL16: Narrow bus variant has a four-byte prefetch queue.
// RL17: Cycle requests wait one or two clocks for the bus handshake.
// RL18: Straps latch at reset release; modes hold until next reset.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module rmss_top
    import rmss_pkg::*;
(
    // Clock and system reset
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    // Board reset and variant strap
    input  wire logic                  reset_in_n,
    input  wire logic                  bus_width_8,
    // Register port
    input  wire rmss_pkg::rmss_regreq_t reg_req,
    output logic [15:0]                reg_rdata,
    // Shared strap pins
    input  wire rmss_pkg::rmss_pins_t  pins_i,
    output rmss_pkg::rmss_pins_t       pins_o,
    output rmss_pkg::rmss_pins_t       pins_oe,
    // Data bus
    input  wire logic [15:0]           ad_i,
    output logic [15:0]                ad_o,
    output logic                       ad_oe,
    // Bus control
    output logic                       wr_strobe_n,
    output logic                       data_buffer_enable_n,
    output logic                       data_direction,
    output logic                       ctrl_oe,
    output logic                       clock_output,
    output logic [1:0]                 latched_addr,
    // Status
    output logic                       core_reset,
    output logic                       isolation_test_mode
);

    localparam int SW = $bits(rmss_pins_t) + 18;
    localparam logic [SW-1:0] SYNC_INIT = {{$bits(rmss_pins_t){1'b1}}, 18'h00000};

    // Wrap a queue pointer at the active depth
    function automatic logic [2:0] wrap(input logic [3:0] p, input logic [3:0] cap);
        logic [3:0] r;
        r = (p >= cap) ? p - cap : p;
        return r[2:0];
    endfunction

    logic [SW-1:0] sync_q;
    rmss_pins_t    pins_s;
    logic [15:0]   ad_s;
    logic          width8_s;
    logic          reset_s;
    rmss_state_t   st_r;
    logic [4:0]    cnt_r;
    logic          phase_r;
    logic          in_reset_r;
    logic          rel;
    logic          iso_r, qs_r, num_r, lockf_r, narrow_r;
    logic [2:0]    num_cnt_r;
    logic          pend_r, wr_cyc_r, fetch_r;
    logic [1:0]    addr_r, la_r;
    logic [2:0]    wait_r;
    logic [15:0]   wdata_r, rdat_r;
    logic          dir_r;
    logic [7:0]    qmem [Q_BYTES_WIDE];
    logic [2:0]    wp_r, rp_r, qcnt_r;
    logic [3:0]    cap;
    logic [1:0]    push_n;
    logic          push, pop, space_ok, start_ok;
    logic          strobe_act, cyc_act, drive;

    // Every pin input passes the synchroniser
    rmss_sync3 #(
        .W    (SW),
        .INIT (SYNC_INIT)
    ) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .d       ({pins_i, ad_i, bus_width_8, reset_in_n}),
        .q       (sync_q)
    );

    // Unpack synchronised inputs; reset is the filtered pin
    assign {pins_s, ad_s, width8_s, reset_s} = sync_q;  // see RL2
    assign core_reset = ~reset_s;                         // see RL1

    // Output clock divider
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
        end
    end
    assign clock_output = phase_r;

    // Reset release pulse
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            in_reset_r <= 1'b1;
        end else begin
            in_reset_r <= core_reset;
        end
    end
    assign rel = in_reset_r & ~core_reset;

    // Strap latches, isolation and queue status cleared by reset, all held until the next one
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            iso_r    <= 1'b0;
            qs_r     <= 1'b0;
            narrow_r <= 1'b0;
        end else if (core_reset) begin
            iso_r    <= 1'b0;
            qs_r     <= 1'b0;
        end else if (rel) begin
            iso_r    <= ~pins_s.upper_memory_select & ~pins_s.lower_memory_select; // see RL7
            qs_r     <= ~pins_s.queue_status_strap;  // see RL9
            narrow_r <= width8_s;                    // see RL18
        end
    end
    assign isolation_test_mode = iso_r;

    // Lock strap fault: sticky through one reset, set wins over clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lockf_r <= 1'b0;
        end else begin
            lockf_r <= (lockf_r & ~(core_reset & ~in_reset_r))
                     | (core_reset & ~pins_s.bus_lock);
        end
    end

    // Numerics: busy high at release and low four clocks later
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            num_r     <= 1'b0;
            num_cnt_r <= 3'h0;
        end else if (core_reset) begin
            num_r     <= 1'b0;
            num_cnt_r <= 3'h0;
        end else if (rel) begin
            num_cnt_r <= pins_s.coproc_busy ? 3'h1 : 3'h0;
        end else if (num_cnt_r == 3'(NUMERICS_DELAY_CLK)) begin
            num_r     <= ~pins_s.coproc_busy;  // see RL10
            num_cnt_r <= 3'h0;
        end else if (num_cnt_r != 3'h0) begin
            num_cnt_r <= num_cnt_r + 3'h1;
        end
    end

    // Queue depth and admission of new cycles
    assign cap      = narrow_r ? 4'(Q_BYTES_NARROW) : 4'(Q_BYTES_WIDE); // see RL15 see RL16
    assign push_n   = narrow_r ? 2'h1 : 2'h2;
    assign space_ok = ({1'b0, qcnt_r} + {2'h0, push_n}) <= cap;
    assign start_ok = reg_req.wr && reg_req.addr == REG_CTRL && reg_req.wdata[CTL_START]
                    && st_r == S_IDLE && !pend_r && !core_reset && !iso_r
                    && (!reg_req.wdata[CTL_FETCH] || reg_req.wdata[CTL_WRITE] || space_ok);

    // Cycle request capture; held until the sequencer takes it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pend_r   <= 1'b0;
            wr_cyc_r <= 1'b0;
            fetch_r  <= 1'b0;
            addr_r   <= 2'h0;
            wait_r   <= 3'h0;
        end else if (core_reset) begin
            pend_r   <= 1'b0;
        end else if (start_ok) begin
            pend_r   <= 1'b1;
            wr_cyc_r <= reg_req.wdata[CTL_WRITE];
            fetch_r  <= reg_req.wdata[CTL_FETCH] & ~reg_req.wdata[CTL_WRITE];
            addr_r   <= reg_req.wdata[CTL_ADDR_LSB +: 2];
            wait_r   <= reg_req.wdata[CTL_WAIT_LSB +: 3];
        end else if (st_r == S_IDLE && !phase_r) begin
            pend_r   <= 1'b0;
        end
    end

    // Bus cycle sequencer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r  <= S_IDLE;
            cnt_r <= 5'h00;
        end else if (core_reset) begin
            case (st_r)
                S_IDLE: begin
                    st_r <= S_IDLE;
                end
                S_ABORT: begin
                    if (cnt_r == 5'(ABORT_DRIVE_CYC - 1)) begin
                        st_r <= S_IDLE;  // see RL5
                    end else begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                default: begin
                    st_r  <= S_ABORT;    // see RL4
                    cnt_r <= 5'h00;
                end
            endcase
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (pend_r && !phase_r) begin
                        st_r <= S_ADDR;  // see RL17
                    end
                end
                S_ADDR: begin
                    if (!phase_r) begin
                        st_r  <= S_STROBE;
                        cnt_r <= 5'(STROBE_CYC - 1) + {1'b0, wait_r, 1'b0}; // see RL13
                    end
                end
                S_STROBE: begin
                    if (cnt_r == 5'h00) begin
                        st_r <= S_RECOV;
                    end else begin
                        cnt_r <= cnt_r - 5'h01;
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end

    // Low address latch moves as the output clock falls in the first state
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            la_r <= 2'h0;
        end else if (st_r == S_ADDR && phase_r && !core_reset) begin
            la_r <= addr_r;  // see RL12
        end
    end
    assign latched_addr = la_r;

    // Direction turns only while the buffer enable is inactive
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dir_r <= 1'b0;
        end else if (core_reset) begin
            dir_r <= 1'b0;
        end else if (st_r == S_ADDR && phase_r) begin
            dir_r <= wr_cyc_r;  // see RL14
        end
    end

    // Pin drive: inactive levels during abort, floated otherwise in reset
    assign strobe_act = st_r == S_STROBE && !core_reset;
    assign cyc_act    = (st_r == S_ADDR || st_r == S_STROBE) && !core_reset;
    assign drive      = !iso_r && (!core_reset || st_r != S_IDLE);  // see RL5 see RL6

    // Control pin levels and enables
    always_comb begin
        pins_o = '1;
        pins_o.queue_status_strap  = qs_r ? (qcnt_r == 3'h0) : ~(strobe_act & ~wr_cyc_r);
        pins_o.upper_memory_select = ~(cyc_act & fetch_r);
        pins_o.lower_memory_select = ~(cyc_act & ~fetch_r);
        pins_oe = drive ? '1 : '0;
        pins_oe.coproc_busy = 1'b0;
    end
    assign wr_strobe_n          = ~(strobe_act & wr_cyc_r);
    assign data_buffer_enable_n = ~strobe_act;
    assign data_direction       = dir_r;
    assign ctrl_oe              = drive;
    assign ad_o                 = wdata_r;
    assign ad_oe                = strobe_act & wr_cyc_r & !iso_r;

    // Read data capture and queue fill at the end of the strobe
    assign push = strobe_act && cnt_r == 5'h00 && !wr_cyc_r && fetch_r;
    assign pop  = reg_req.rd && reg_req.addr == REG_QUEUE && qcnt_r != 3'h0;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdat_r <= 16'h0000;
        end else if (strobe_act && cnt_r == 5'h00 && !wr_cyc_r) begin
            rdat_r <= ad_s;
        end
    end

    // Prefetch queue storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            qmem[wp_r] <= ad_s[7:0];
            if (!narrow_r) begin
                qmem[wrap({1'b0, wp_r} + 4'h1, cap)] <= ad_s[15:8];
            end
        end
    end

    // Queue pointers and count
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wp_r   <= 3'h0;
            rp_r   <= 3'h0;
            qcnt_r <= 3'h0;
        end else if (core_reset) begin
            wp_r   <= 3'h0;
            rp_r   <= 3'h0;
            qcnt_r <= 3'h0;
        end else begin
            if (push) begin
                wp_r <= wrap({1'b0, wp_r} + {2'h0, push_n}, cap);
            end
            if (pop) begin
                rp_r <= wrap({1'b0, rp_r} + 4'h1, cap);
            end
            qcnt_r <= qcnt_r + (push ? {1'b0, push_n} : 3'h0) - {2'h0, pop};
        end
    end

    // Write data register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wdata_r <= 16'h0000;
        end else if (reg_req.wr && reg_req.addr == REG_WDATA) begin
            wdata_r <= reg_req.wdata;
        end
    end

    // Register read, answered in the next cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_req.rd) begin
            reg_rdata <= 16'h0000;
        end else if (reg_req.addr == REG_CTRL) begin
            reg_rdata <= {8'h00, wait_r, addr_r, fetch_r, wr_cyc_r, pend_r};
        end else if (reg_req.addr == REG_WDATA) begin
            reg_rdata <= wdata_r;
        end else if (reg_req.addr == REG_RDATA) begin
            reg_rdata <= rdat_r;
        end else if (reg_req.addr == REG_MODE) begin
            reg_rdata <= {9'h000, st_r != S_IDLE, core_reset, narrow_r,
                          lockf_r, num_r, qs_r, iso_r};
        end else if (reg_req.addr == REG_QUEUE) begin
            reg_rdata <= {4'h0, qcnt_r, pop, pop ? qmem[rp_r] : 8'h00};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_drive_inactive;
        ctrl_oe && wr_strobe_n && data_buffer_enable_n;
    endsequence

    sequence s_strobe_hold;
        (!data_buffer_enable_n)[*4];
    endsequence

    chk_reset_idle: assert property (core_reset && st_r == S_IDLE |=> st_r == S_IDLE) // see RL1
        else $error("sequencer left idle during reset");
    chk_abort_now: assert property (core_reset |-> wr_strobe_n && data_buffer_enable_n) // see RL4
        else $error("strobe active during reset");
    chk_abort_float: assert property ($rose(core_reset) && st_r != S_IDLE && !iso_r // see RL5
        |-> s_drive_inactive[*2] ##1 (!ctrl_oe || !core_reset))
        else $error("abort drive then float order broken");
    chk_strap_input: assert property (core_reset && st_r == S_IDLE |-> pins_oe == '0) // see RL6
        else $error("strap pin driven during reset");
    chk_iso_latch: assert property (rel |=> iso_r == ($past(~pins_s.upper_memory_select) // see RL7
        && $past(~pins_s.lower_memory_select)))
        else $error("isolation strap not latched");
    chk_qs_latch: assert property (rel |=> qs_r == !$past(pins_s.queue_status_strap)) // see RL9
        else $error("queue status strap not latched");
    chk_num_timing: assert property ($rose(num_r) |-> $past(rel, 5)) // see RL10
        else $error("numerics enabled at wrong time");
    chk_addr_edge: assert property ($changed(la_r) |-> $fell(clock_output) && $past(st_r == S_ADDR)) // see RL12
        else $error("latched address moved off first state end");
    chk_strobe_len: assert property ($fell(data_buffer_enable_n) |-> s_strobe_hold) // see RL13
        else $error("strobe shorter than minimum");
    chk_dir_order: assert property ($fell(data_direction) |-> data_buffer_enable_n // see RL14
        && $past(data_buffer_enable_n))
        else $error("direction turned with buffer enabled");
    chk_queue_cap: assert property ({1'b0, qcnt_r} <= cap) // see RL15 see RL16
        else $error("queue over depth");
    chk_handshake: assert property ($rose(pend_r) && !core_reset // see RL17
        |-> ##[1:2] (st_r == S_ADDR || core_reset))
        else $error("request not taken within two clocks");
    chk_mode_hold: assert property (!core_reset && !rel |=> $stable(iso_r) && $stable(qs_r)) // see RL18
        else $error("mode changed outside reset release");

endmodule

// [rmss_pkg.sv]
// Package for the reset and mode strap sampler: timing, map, types.
// Assumes a single 10 MHz system clock and a 16-bit register port.
package rmss_pkg;

    // System clock and derived output clock
    localparam int CLK_PERIOD_NS   = 100;
    localparam int OUT_CLK_DIV     = 2;
    localparam int T_OUT_NS        = CLK_PERIOD_NS * OUT_CLK_DIV;

    // Least strobe width: two output clocks less 5 ns, rounded up
    localparam int STROBE_MIN_NS   = 2 * T_OUT_NS - 5;
    localparam int STROBE_CYC      = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Coprocessor strap is checked again this many clocks after release
    localparam int NUMERICS_DELAY_CLK = 4;

    // Cycles in the abort state; control outputs stay driven inactive one cycle more than this
    localparam int ABORT_DRIVE_CYC = 1;

    // Prefetch queue depth per bus variant
    localparam int Q_BYTES_WIDE    = 6;
    localparam int Q_BYTES_NARROW  = 4;

    // Register offsets
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_WDATA = 8'h01;
    localparam logic [7:0] REG_RDATA = 8'h02;
    localparam logic [7:0] REG_MODE  = 8'h03;
    localparam logic [7:0] REG_QUEUE = 8'h04;

    // Control register fields
    localparam int CTL_START    = 0;
    localparam int CTL_WRITE    = 1;
    localparam int CTL_FETCH    = 2;
    localparam int CTL_ADDR_LSB = 3;
    localparam int CTL_WAIT_LSB = 5;

    // Mode register fields
    localparam int MD_ISO    = 0;
    localparam int MD_QS     = 1;
    localparam int MD_NUM    = 2;
    localparam int MD_LOCKF  = 3;
    localparam int MD_NARROW = 4;
    localparam int MD_INRST  = 5;
    localparam int MD_BUSY   = 6;

    // Queue register fields
    localparam int QR_VALID   = 8;
    localparam int QR_CNT_LSB = 9;

    // Shared strap pins, one bit each
    typedef struct packed {
        logic queue_status_strap;
        logic upper_memory_select;
        logic lower_memory_select;
        logic mid_select_0_coproc_request;
        logic mid_select_1_coproc_fault;
        logic bus_lock;
        logic coproc_busy;
    } rmss_pins_t;

    // Register port request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } rmss_regreq_t;

    // Bus cycle states
    typedef enum logic [4:0] {
        S_IDLE   = 5'h01,
        S_ADDR   = 5'h02,
        S_STROBE = 5'h04,
        S_RECOV  = 5'h08,
        S_ABORT  = 5'h10
    } rmss_state_t;

endpackage

// [rmss_sync3.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
module rmss_sync3 #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] ff1_r;
    logic [W-1:0] ff2_r;
    logic [W-1:0] ff3_r;

    // Chain; output moves only where stages two and three agree
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ff1_r <= INIT;
            ff2_r <= INIT;
            ff3_r <= INIT;
            q     <= INIT;
        end else begin
            ff1_r <= d;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
            q     <= (ff2_r & ~(ff2_r ^ ff3_r)) | (q & (ff2_r ^ ff3_r));
        end
    end

endmodule

// [rmss_board.sv]
// Board model: reset generator, strap pull-ups and a memory on the data bus.
// Assumes the bench changes its controls just after the rising clock edge.
`timescale 1ns/1ps
module rmss_board
    import rmss_pkg::*;
#(
    parameter logic [15:0] RD_WORD = 16'h5AC3
) (
    // Clock and bench controls
    input  wire logic                 clk_sys,
    input  wire logic                 rst_req,
    input  wire rmss_pkg::rmss_pins_t strap_lo,
    input  wire logic                 num_en,
    // Device side
    input  wire rmss_pkg::rmss_pins_t pins_o,
    input  wire rmss_pkg::rmss_pins_t pins_oe,
    input  wire logic [15:0]          ad_o,
    input  wire logic                 ad_oe,
    output logic                      reset_in_n,
    output rmss_pkg::rmss_pins_t      pins_i,
    output logic [15:0]               ad_i
);
    logic [3:0] rel_cnt;
    logic       strap_on;
    logic [6:0] strap_eff;

    // Reset pin low from power-on and while asked
    initial begin
        reset_in_n = 1'b0;
        forever @(posedge clk_sys) reset_in_n <= !rst_req;
    end

    // Cycles since release; straps stay put well past it
    initial begin
        rel_cnt = 4'h0;
        forever @(posedge clk_sys) begin
            if (!reset_in_n)
                rel_cnt <= 4'h0;
            else if (rel_cnt != 4'hF)
                rel_cnt <= rel_cnt + 4'h1;
        end
    end
    assign strap_on = !reset_in_n || rel_cnt < 4'h8;

    // Pull-ups unless driven; straps pull low; busy drops four clocks on
    always_comb begin
        // Lock pin is never pulled low, whatever the bench asks
        strap_eff = strap_lo & {7{strap_on}} & 7'h7D;
        pins_i = (pins_oe & pins_o) | (~pins_oe & ~strap_eff);
        if (num_en && rel_cnt >= 4'h4)
            pins_i.coproc_busy = 1'b0;
    end

    // Memory answers whenever the device is not driving
    assign ad_i = ad_oe ? ad_o : RD_WORD;
endmodule

// [rmss_top_tb.sv]
// Self-checking bench for the reset and mode strap sampler.
// Assumes the board model stands on the strap pins and data bus.
`timescale 1ns/1ps
module rmss_top_tb;
    import rmss_pkg::*;
    logic clk_sys, rstn, rst_req, num_en, bus_width_8, reset_in_n, ad_oe, wr_strobe_n;
    logic dben_n, data_direction, ctrl_oe, clock_output, core_reset, isolation_test_mode;
    logic dir_q, dben_q, clko_q;
    logic [1:0] latched_addr, la_q;
    logic [15:0] reg_rdata, ad_i, ad_o, d;
    rmss_regreq_t reg_req;
    rmss_pins_t strap_lo, pins_i, pins_o, pins_oe;
    int n_mismatch, check_count, i;

    rmss_top DUT (.clk_sys(clk_sys), .rstn(rstn), .reset_in_n(reset_in_n),
        .bus_width_8(bus_width_8), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .pins_i(pins_i), .pins_o(pins_o), .pins_oe(pins_oe), .ad_i(ad_i), .ad_o(ad_o),
        .ad_oe(ad_oe), .wr_strobe_n(wr_strobe_n), .data_buffer_enable_n(dben_n),
        .data_direction(data_direction), .ctrl_oe(ctrl_oe), .clock_output(clock_output),
        .latched_addr(latched_addr), .core_reset(core_reset),
        .isolation_test_mode(isolation_test_mode));
    rmss_board board (.clk_sys(clk_sys), .rst_req(rst_req), .strap_lo(strap_lo),
        .num_en(num_en), .pins_o(pins_o), .pins_oe(pins_oe), .ad_o(ad_o), .ad_oe(ad_oe),
        .reset_in_n(reset_in_n), .pins_i(pins_i), .ad_i(ad_i));

    // 10 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic give_up(input string what);
        chk(what, 16'h0001, 16'h0000);
        tally_and_finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys) reg_req <= '{1'b0, 1'b1, a, v};
        @(posedge clk_sys) reg_req <= '0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk_sys) reg_req <= '{1'b1, 1'b0, a, 16'h0000};
        @(posedge clk_sys) reg_req <= '0;
        #1 v = reg_rdata;
    endtask

    // Start a cycle and count the strobe cycles it makes
    task automatic run_cycle(input logic [15:0] ctl, input int exp);
        int n;
        n = 0;
        reg_wr(REG_CTRL, ctl);
        for (int k = 0; k < 60; k++) begin
            @(negedge clk_sys);
            if (dben_n === 1'b0)
                n++;
            else if (n > 0)
                break;
        end
        chk("strobe cycles", exp[15:0], n[15:0]);
    endtask

    // Reset through the board pin with given straps, then read the modes
    task automatic reset_cycle(input rmss_pins_t s, input logic n, w, input logic [15:0] m);
        @(posedge clk_sys);
        strap_lo <= s;
        num_en <= n;
        bus_width_8 <= w;
        rst_req <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1 chk("strap enables", 16'h0000, pins_oe);
        chk("core reset", 16'h0001, core_reset);
        @(posedge clk_sys) rst_req <= 1'b0;
        for (i = 0; i < 40 && core_reset !== 1'b0; i++)
            @(negedge clk_sys);
        if (core_reset !== 1'b0)
            give_up("reset release");
        repeat (12) @(posedge clk_sys);
        reg_rd(REG_MODE, d);
        chk("mode", m, d & 16'h007F);
        chk("isolation pin", m & 16'h0001, isolation_test_mode);
    endtask

    task automatic fill_queue(input int depth, input int bpf);
        for (int k = 0; k <= depth / bpf; k++)
            run_cycle(16'h0005, (k < depth / bpf) ? 4 : 0);
        reg_rd(REG_QUEUE, d);
        chk("queue head", {4'h0, depth[2:0], 1'b1, 8'hC3}, d);
    endtask

    // Latch and direction ordering seen at the falling edge
    always @(negedge clk_sys) begin
        if (rstn === 1'b1 && core_reset === 1'b0) begin
            if (dir_q === 1'b1 && data_direction === 1'b0)
                chk("buffer off before receive", 16'h0001, dben_q);
            if (latched_addr !== la_q)
                chk("latch at state end", 16'h0001, clko_q & ~clock_output);
            if (dben_n === 1'b0)
                chk("one select low", 16'h0001,
                    pins_o.upper_memory_select ^ pins_o.lower_memory_select);
            if (wr_strobe_n === 1'b0)
                chk("write data", 16'h3C96, ad_o);
        end
        dir_q = data_direction;
        dben_q = dben_n;
        clko_q = clock_output;
        la_q = latched_addr;
    end

    initial begin
        rstn = 1'b0;
        rst_req = 1'b1;
        num_en = 1'b0;
        bus_width_8 = 1'b0;
        strap_lo = '0;
        reg_req = '0;
        n_mismatch = 0;
        check_count = 0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        reset_cycle('0, 1'b0, 1'b0, 16'h0000);
        $display("test default reset done");
        reg_wr(REG_WDATA, 16'h3C96);
        run_cycle(16'h0013, 4);
        chk("latched addr", 16'h0002, latched_addr);
        run_cycle(16'h0029, 6);
        reg_rd(REG_RDATA, d);
        chk("read data", 16'h5AC3, d);
        fill_queue(Q_BYTES_WIDE, 2);
        $display("test bus cycles done");
        reg_wr(REG_CTRL, 16'h00E3);
        for (i = 0; i < 20 && dben_n !== 1'b0; i++)
            @(negedge clk_sys);
        if (dben_n !== 1'b0)
            give_up("abort strobe start");
        @(posedge clk_sys) rst_req <= 1'b1;
        for (i = 0; i < 20 && core_reset !== 1'b1; i++)
            @(negedge clk_sys);
        if (core_reset !== 1'b1)
            give_up("abort reset entry");
        chk("abort strobe", 16'h0001, wr_strobe_n);
        chk("abort drive", 16'h0001, ctrl_oe);
        repeat (2) @(negedge clk_sys);
        chk("abort float", 16'h0000, ctrl_oe);
        reset_cycle(7'h40, 1'b1, 1'b1, 16'h0016);
        fill_queue(Q_BYTES_NARROW, 1);
        $display("test abort and strap modes done");
        reset_cycle(7'b0110000, 1'b0, 1'b0, 16'h0001);
        run_cycle(16'h0013, 0);
        chk("isolated enables", 16'h0000, {pins_oe, ctrl_oe, ad_oe});
        $display("test isolation done");
        tally_and_finish;
    end
endmodule
